// [design/ics_ctrl.sv]
// ics_ctrl: control register, first and second status registers, line
// hold, shared interrupt request and low-power behaviour of the bus port.
// assumes a byte engine on clk_i delivers ics_ev_s pulses; scl/sda pins
// are asynchronous and are synchronised here.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module ics_ctrl
  import ics_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ics_ev_s ev_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic [7:0] own_addr_i,
  input wire logic halt_i,
  input wire logic imask_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o,
  output logic periph_on_o,
  output logic start_req_o,
  output logic stop_req_o,
  output logic master_o,
  output logic rx_only_o,
  output logic [7:0] tx_byte_o,
  output logic tx_load_o
);

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] tx_byte_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire hit_ctrl = wb_adr_i == ICS_ADR_CTRL;
  wire hit_sr1 = wb_adr_i == ICS_ADR_SR1;
  wire hit_sr2 = wb_adr_i == ICS_ADR_SR2;
  wire hit_data = wb_adr_i == ICS_ADR_DATA;
  wire ctrl_wr = wr & hit_ctrl;
  wire sr1_rd = rd & hit_sr1;
  wire sr2_rd = rd & hit_sr2;
  wire data_wr = wr & hit_data;
  wire data_rd = rd & hit_data;

  wire pe = ctrl_reg[ICS_CR_PE];
  // halt freezes every flop but the bus answer, the pin synchronisers and tx_load_o, which drops
  wire run = ~halt_i;
  wire active = pe & run;
  wire irq_enable = ctrl_reg[ICS_CR_ITE];
  wire ack_en = ctrl_reg[ICS_CR_ACK];
  wire gc_en = ctrl_reg[ICS_CR_GC];
  wire start_bit = ctrl_reg[ICS_CR_START];
  wire stop_bit = ctrl_reg[ICS_CR_STOP];

  // ----------------------------------------------------------------
  // pin synchronisers and start/stop detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic sda_prev_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_reg <= ICS_SYNC_RST;
      sda_sync_reg <= ICS_SYNC_RST;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      sda_prev_reg <= sda_sync_reg[1];
    end
  end
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire start_det = scl_s & sda_prev_reg & ~sda_s;
  wire stop_det = scl_s & ~sda_prev_reg & sda_s;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic header_sent_flag;
  logic direction_flag;
  logic busy_flag;
  logic byte_finished_flag;
  logic address_matched_flag;
  logic master_mode_flag;
  logic start_generated_flag;
  logic ack_failure_flag;
  logic stop_detected_flag;
  logic arbitration_lost_flag;
  logic bus_error_flag;
  logic general_call_seen;
  logic post_address_event;
  logic btf_defer_reg;
  logic btf_defer_tx_reg;
  logic addressed_reg;
  logic sr1_seen_reg;
  logic sr2_seen_reg;

  // address compare; 01h never matches
  wire addr_ign = ev_i.addr_byte == ICS_IGNORE_BYTE;
  wire addr_gc = gc_en & (ev_i.addr_byte == ICS_GCALL_BYTE);
  wire addr_own = ~addr_ign & (ev_i.addr_byte[7:1] == own_addr_i[7:1]);
  wire addr_hit = ~master_mode_flag & ev_i.addr_valid & ack_en
                  & (addr_own | addr_gc);

  wire ev_byte = active & ev_i.byte_done;
  // a byte finished while the post-address event is pending waits for it to be cleared
  wire btf_now = ev_byte & ~post_address_event;
  wire ev6_clr = sr1_seen_reg & ctrl_wr & wb_dat_i[ICS_CR_PE];
  wire btf_late = btf_defer_reg & ev6_clr;
  // tx byte needs a data write, rx byte a data read
  wire btf_clr = sr1_seen_reg
                 & ((direction_flag & data_wr)
                 | (~direction_flag & data_rd));
  // slave stop request frees the clock line once the byte is done
  wire slave_rel = stop_bit & ~master_mode_flag & byte_finished_flag;
  wire lost = active & ev_i.arb_lost;

  // flag updates: clear terms first, set terms last so a set wins
  always_ff @(posedge clk_i) begin
    if (rst_i || (!pe && run)) begin
      header_sent_flag <= 1'b0;
      direction_flag <= 1'b0;
      byte_finished_flag <= 1'b0;
      address_matched_flag <= 1'b0;
      master_mode_flag <= 1'b0;
      start_generated_flag <= 1'b0;
      ack_failure_flag <= 1'b0;
      stop_detected_flag <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      bus_error_flag <= 1'b0;
      general_call_seen <= 1'b0;
      post_address_event <= 1'b0;
      btf_defer_reg <= 1'b0;
      btf_defer_tx_reg <= 1'b0;
      addressed_reg <= 1'b0;
      sr1_seen_reg <= 1'b0;
      sr2_seen_reg <= 1'b0;
    end else if (run) begin
      // access sequences
      if (sr1_rd) sr1_seen_reg <= 1'b1;
      else if (data_wr || data_rd || ctrl_wr) sr1_seen_reg <= 1'b0;
      if (sr2_rd) sr2_seen_reg <= 1'b1;
      else if (data_wr) sr2_seen_reg <= 1'b0;

      if (sr2_seen_reg && data_wr) header_sent_flag <= 1'b0;
      if (ev_i.header_sent) header_sent_flag <= 1'b1;

      if (sr1_seen_reg && data_wr) start_generated_flag <= 1'b0;
      if (ev_i.start_sent) start_generated_flag <= 1'b1;

      if (sr1_rd) address_matched_flag <= 1'b0;
      if (addr_hit) address_matched_flag <= 1'b1;

      if (ev6_clr) post_address_event <= 1'b0;
      if (ev_i.addr_sent) post_address_event <= 1'b1;

      if (btf_clr || slave_rel) byte_finished_flag <= 1'b0;
      if (btf_clr || stop_det || lost) direction_flag <= 1'b0;
      if (btf_late) btf_defer_reg <= 1'b0;
      if (ev_byte && post_address_event) begin
        btf_defer_reg <= 1'b1;
        btf_defer_tx_reg <= ev_i.byte_tx;
      end
      if (btf_now || btf_late) begin
        byte_finished_flag <= 1'b1;
        // general call slave is receive only
        direction_flag <= (btf_now ? ev_i.byte_tx : btf_defer_tx_reg)
                          & ~general_call_seen;
      end

      if (stop_det || lost) master_mode_flag <= 1'b0;
      if (ctrl_wr && wb_dat_i[ICS_CR_START] && (master_mode_flag || !busy_flag))
        master_mode_flag <= 1'b1;

      if (stop_det) general_call_seen <= 1'b0;
      if (addr_hit && addr_gc) general_call_seen <= 1'b1;

      if (stop_det) addressed_reg <= 1'b0;
      if (addr_hit) addressed_reg <= 1'b1;

      if (sr2_rd) begin
        ack_failure_flag <= 1'b0;
        stop_detected_flag <= 1'b0;
        arbitration_lost_flag <= 1'b0;
        bus_error_flag <= 1'b0;
      end
      if (ev_i.ack_fail) ack_failure_flag <= 1'b1;
      if (stop_det && addressed_reg && !master_mode_flag)
        stop_detected_flag <= 1'b1;
      if (ev_i.arb_lost) arbitration_lost_flag <= 1'b1;
      if (ev_i.bus_err) bus_error_flag <= 1'b1;
    end
  end

  // busy keeps its stale value while the port is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_flag <= 1'b0;
    end else if (active) begin
      if (stop_det || ev_i.bus_err) busy_flag <= 1'b0;
      if (start_det) busy_flag <= 1'b1;
    end
  end

  // summary flag: any pending event or error
  wire any_event_flag = header_sent_flag | byte_finished_flag
                        | address_matched_flag | start_generated_flag
                        | ack_failure_flag | stop_detected_flag
                        | arbitration_lost_flag | bus_error_flag
                        | post_address_event;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [7:0] ctrl_next;
  always_comb begin
    ctrl_next = ctrl_reg;
    if (!pe) begin
      // stop survives disable, everything else drops
      ctrl_next = ICS_CTRL_RST;
      ctrl_next[ICS_CR_STOP] = stop_bit;
    end
    if (ctrl_wr) begin
      if (!pe) begin
        ctrl_next[ICS_CR_PE] = wb_dat_i[ICS_CR_PE];
      end else begin
        ctrl_next[5:0] = wb_dat_i[5:0];
      end
    end
    if (ev_i.start_sent) ctrl_next[ICS_CR_START] = 1'b0;
    if (ev_i.stop_sent && master_mode_flag)
      ctrl_next[ICS_CR_STOP] = 1'b0;
    ctrl_next[7:6] = 2'b00;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= ICS_CTRL_RST;
      tx_byte_reg <= ICS_SR_RST;
      tx_load_o <= 1'b0;
    end else if (run) begin
      ctrl_reg <= ctrl_next;
      tx_load_o <= data_wr & pe;
      if (data_wr) tx_byte_reg <= wb_dat_i[7:0];
    end else begin
      tx_load_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wishbone read data and ack
  // ----------------------------------------------------------------
  wire [7:0] sr1_val = {any_event_flag, header_sent_flag, direction_flag,
                        busy_flag, byte_finished_flag, address_matched_flag,
                        master_mode_flag, start_generated_flag};
  wire [7:0] sr2_val = {3'b000, ack_failure_flag, stop_detected_flag,
                        arbitration_lost_flag, bus_error_flag,
                        general_call_seen};
  // unmapped addresses read zero; status writes land nowhere
  wire [7:0] rd_val = hit_ctrl ? ctrl_reg :
                      hit_sr1 ? sr1_val :
                      hit_sr2 ? sr2_val :
                      hit_data ? rx_byte_i : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else begin
      wb_ack_reg <= req;
      if (rd) wb_dat_reg <= {24'h00_0000, rd_val};
    end
  end
  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  // ----------------------------------------------------------------
  // pins, requests and interrupt
  // ----------------------------------------------------------------
  wire hold = header_sent_flag | start_generated_flag
              | byte_finished_flag | address_matched_flag
              | post_address_event;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = active & hold & ~slave_rel;
  // engine asks for the ack slot; address acks only on a hit
  assign sda_oe_o = active & ack_en & ev_i.ack_slot
                    & (~ev_i.addr_valid | addr_hit);
  assign start_req_o = active & start_bit
                       & (master_mode_flag | ~busy_flag);
  assign stop_req_o = active & stop_bit & master_mode_flag;
  // flags drop one edge after disable; hide that cycle at the pin
  assign master_o = master_mode_flag & pe;
  assign rx_only_o = general_call_seen;
  assign periph_on_o = pe;
  assign tx_byte_o = tx_byte_reg;
  // no wake from halt; mask blocks the request
  assign irq_o = active & irq_enable & ~imask_i & any_event_flag;

endmodule // ics_ctrl

// [design/ics_pkg.sv]
// ics_pkg: constants and carriers of the two-wire bus control/status block.
// assumes a byte engine on the same clock reports bus events to the block.
package ics_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ICS_ADR_CTRL = 4'h0;
  localparam logic [3:0] ICS_ADR_SR1 = 4'h4;
  localparam logic [3:0] ICS_ADR_SR2 = 4'h8;
  localparam logic [3:0] ICS_ADR_DATA = 4'hC;

  // ----------------------------------------------------------------
  // control bit positions
  // ----------------------------------------------------------------
  localparam int ICS_CR_PE = 5;
  localparam int ICS_CR_GC = 4;
  localparam int ICS_CR_START = 3;
  localparam int ICS_CR_ACK = 2;
  localparam int ICS_CR_STOP = 1;
  localparam int ICS_CR_ITE = 0;

  // ----------------------------------------------------------------
  // reset values and special addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ICS_CTRL_RST = 8'h00;
  localparam logic [7:0] ICS_SR_RST = 8'h00;
  localparam logic [7:0] ICS_GCALL_BYTE = 8'h00;
  localparam logic [7:0] ICS_IGNORE_BYTE = 8'h01;
  localparam logic [1:0] ICS_SYNC_RST = 2'h3;

  // ----------------------------------------------------------------
  // events from the byte engine, one-cycle pulses
  // ----------------------------------------------------------------
  typedef struct packed {
    logic header_sent;
    logic byte_done;
    logic byte_tx;
    logic addr_valid;
    logic [7:0] addr_byte;
    logic ack_slot;
    logic start_sent;
    logic stop_sent;
    logic addr_sent;
    logic ack_fail;
    logic arb_lost;
    logic bus_err;
  } ics_ev_s;

endpackage

// [dv/ics_bus_model.sv]
// ics_bus_model: far side of the port, bus conditions on the pins and
// byte engine event pulses. assumes the bench wires pins open-drain.
`timescale 1ns/1ps
module ics_bus_model
  import ics_pkg::*;
(
  input wire logic clk_i,
  output logic scl_o,
  output logic sda_o,
  output ics_ev_s ev_o
);
  // pins idle high, clock stands still outside frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    ev_o = '0;
  end
  task automatic start_cond();
    sda_o = 1'b1;
    scl_o = 1'b1;
    #16 sda_o = 1'b0;
    #16 scl_o = 1'b0;
  endtask
  task automatic stop_cond();
    scl_o = 1'b0;
    #16 sda_o = 1'b0;
    #16 scl_o = 1'b1;
    #16 sda_o = 1'b1;
  endtask
  task automatic pulse(input ics_ev_s e);
    @(posedge clk_i);
    ev_o <= e;
    @(posedge clk_i);
    ev_o <= '0;
  endtask
endmodule // ics_bus_model

// [dv/ics_ctrl_assertions.sv]
// ics_ctrl_assertions: port-level checks of the bus control block.
// assumes single clock domain, rst_i synchronous active high.
`timescale 1ns/1ps
module ics_ctrl_assertions
  import ics_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ics_ev_s ev_i,
  input wire logic halt_i,
  input wire logic imask_i,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic irq_o,
  input wire logic periph_on_o,
  input wire logic start_req_o,
  input wire logic stop_req_o,
  input wire logic master_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wb_take = wb_req && !wb_ack_o;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_take: assert property (wb_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_irq_mask_gate: assert property (imask_i |-> !irq_o)
    else $error("interrupt raised while masked");
  a_halt_no_wake: assert property (halt_i |->
    !irq_o && !scl_oe_o && !sda_oe_o)
    else $error("halt left request or line drive active");
  a_halt_regs_frozen: assert property (halt_i |=>
    $stable(periph_on_o) && $stable(master_o) && $stable(stop_req_o))
    else $error("register changed during halt");
  a_off_lines_free: assert property (!periph_on_o |->
    !scl_oe_o && !sda_oe_o && !irq_o)
    else $error("line driven while disabled");
  a_off_ctrl_clear: assert property (!periph_on_o |->
    !master_o && !start_req_o)
    else $error("control state kept while disabled");
  a_ctrl_rsvd_zero: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == ICS_ADR_CTRL |-> wb_dat_o[31:6] == 26'h0)
    else $error("reserved control bits read nonzero");
  a_start_auto_clear: assert property (ev_i.start_sent && !halt_i &&
    !wb_req |=> !start_req_o)
    else $error("start request kept after start sent");
  a_stop_master_clear: assert property (ev_i.stop_sent && master_o &&
    !halt_i && !wb_req |=> !stop_req_o)
    else $error("stop request kept after stop sent");
endmodule // ics_ctrl_assertions

bind ics_ctrl ics_ctrl_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .ev_i, .halt_i,
  .imask_i, .scl_oe_o, .sda_oe_o, .irq_o, .periph_on_o, .start_req_o,
  .stop_req_o, .master_o);

// [dv/test_ics_ctrl.sv]
// test_ics_ctrl: register-level tests of the bus control block.
// assumes ics_bus_model as far side; pins are wired-and here.
`timescale 1ns/1ps
module test_ics_ctrl
  import ics_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, halt_i = 1'b0, imask_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, periph_on_o;
  logic start_req_o, stop_req_o, master_o, rx_only_o, tx_load_o;
  logic m_scl, m_sda, scl_i, sda_i;
  logic [7:0] tx_byte_o, q;
  ics_ev_s ev_i;
  int n_errors = 0, samples_checked = 0;
  int n_loads = 0, n_acks = 0;
  always #2 clk_i = ~clk_i;
  assign scl_i = m_scl & ~scl_oe_o;
  assign sda_i = m_sda & ~sda_oe_o;
  // short pulses are counted as they stand, checked at the end
  always @(posedge clk_i) if (tx_load_o === 1'b1) n_loads++;
  always @(posedge clk_i) if (sda_oe_o === 1'b1) n_acks++;

  ics_ctrl u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ev_i,
    .rx_byte_i(8'h5C), .own_addr_i(8'hA4), .halt_i, .imask_i, .scl_i,
    .sda_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o, .irq_o, .periph_on_o,
    .start_req_o, .stop_req_o, .master_o, .rx_only_o, .tx_byte_o,
    .tx_load_o);
  ics_bus_model u_bus (.clk_i, .scl_o(m_scl), .sda_o(m_sda), .ev_o(ev_i));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk1("ack", 1'b1, wb_ack_o);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00, q);
    chk8(nm, e, q);
  endtask
  task automatic evp(input int k, input logic [7:0] b);
    ics_ev_s e;
    e = '0;
    case (k)
      0: begin
        e.addr_valid = 1'b1;
        e.addr_byte = b;
        e.ack_slot = 1'b1;
      end
      1: e.byte_done = 1'b1;
      2: begin
        e.byte_done = 1'b1;
        e.byte_tx = 1'b1;
      end
      3: e.ack_fail = 1'b1;
      4: e.start_sent = 1'b1;
      6: e.header_sent = 1'b1;
      7: e.addr_sent = 1'b1;
      default: e.stop_sent = 1'b1;
    endcase
    u_bus.pulse(e);
    // flags land on the edge that ends the pulse; look one edge later
    @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ICS_ADR_CTRL, 8'h00, "ctrl reset");
    rd(ICS_ADR_SR1, 8'h00, "idle before enable");
    wr(ICS_ADR_SR1, 8'hFF);
    rd(ICS_ADR_SR1, 8'h00, "sr1 readonly");
    rd(4'h2, 8'h00, "unmapped");
    wr(ICS_ADR_CTRL, 8'hFF);
    rd(ICS_ADR_CTRL, 8'h20, "ctrl first write");
    wr(ICS_ADR_CTRL, 8'h35);
    rd(ICS_ADR_CTRL, 8'h35, "ctrl second write");
    u_bus.start_cond();
    repeat (8) @(posedge clk_i);
    rd(ICS_ADR_SR1, 8'h10, "busy on start");
    $display("test enable done");
    evp(0, 8'hA4);
    rd(ICS_ADR_SR1, 8'h94, "own match");
    rd(ICS_ADR_SR1, 8'h10, "match cleared");
    evp(0, 8'h01);
    rd(ICS_ADR_SR1, 8'h10, "addr 01 ignored");
    evp(0, 8'h00);
    chk1("hold clock", 1'b1, scl_oe_o);
    chk1("rx only", 1'b1, rx_only_o);
    chk1("irq", 1'b1, irq_o);
    imask_i <= 1'b1;
    @(posedge clk_i);
    chk1("irq masked", 1'b0, irq_o);
    imask_i <= 1'b0;
    halt_i <= 1'b1;
    @(posedge clk_i);
    chk1("irq halt", 1'b0, irq_o);
    halt_i <= 1'b0;
    @(posedge clk_i);
    chk1("irq wait wake", 1'b1, irq_o);
    rd(ICS_ADR_SR1, 8'h94, "general call");
    evp(1, 8'h00);
    rd(ICS_ADR_SR1, 8'h98, "rx byte");
    rd(ICS_ADR_DATA, 8'h5C, "rx data");
    evp(2, 8'h00);
    rd(ICS_ADR_SR1, 8'h98, "general call tx masked");
    wr(ICS_ADR_CTRL, 8'h37);
    chk1("slave release", 1'b0, scl_oe_o);
    rd(ICS_ADR_SR1, 8'h10, "slave release flags");
    wr(ICS_ADR_CTRL, 8'h35);
    evp(3, 8'h00);
    rd(ICS_ADR_SR2, 8'h11, "ack fail");
    rd(ICS_ADR_SR2, 8'h01, "errors cleared");
    rd(ICS_ADR_SR1, 8'h10, "event cleared");
    u_bus.stop_cond();
    repeat (8) @(posedge clk_i);
    rd(ICS_ADR_SR2, 8'h08, "stop flag");
    rd(ICS_ADR_SR1, 8'h00, "busy cleared");
    $display("test slave done");
    wr(ICS_ADR_CTRL, 8'h3D);
    chk1("master", 1'b1, master_o);
    evp(4, 8'h00);
    chk1("start cleared", 1'b0, start_req_o);
    chk1("hold on start", 1'b1, scl_oe_o);
    rd(ICS_ADR_SR1, 8'h83, "start flag");
    wr(ICS_ADR_DATA, 8'hA0);
    chk8("tx byte out", 8'hA0, tx_byte_o);
    rd(ICS_ADR_SR1, 8'h02, "start flag cleared");
    evp(2, 8'h00);
    rd(ICS_ADR_SR1, 8'hAA, "tx byte");
    wr(ICS_ADR_DATA, 8'h11);
    rd(ICS_ADR_SR1, 8'h02, "tx cleared");
    evp(6, 8'h00);
    rd(ICS_ADR_SR1, 8'hC2, "header flag");
    rd(ICS_ADR_SR2, 8'h00, "sr2 arm");
    wr(ICS_ADR_DATA, 8'h22);
    rd(ICS_ADR_SR1, 8'h02, "header cleared");
    evp(7, 8'h00);
    chk1("hold post addr", 1'b1, scl_oe_o);
    rd(ICS_ADR_SR1, 8'h82, "post addr event");
    wr(ICS_ADR_CTRL, 8'h35);
    rd(ICS_ADR_SR1, 8'h02, "post addr cleared");
    wr(ICS_ADR_CTRL, 8'h37);
    evp(5, 8'h00);
    chk1("stop cleared", 1'b0, stop_req_o);
    u_bus.stop_cond();
    repeat (8) @(posedge clk_i);
    chk1("master off on stop", 1'b0, master_o);
    $display("test master done");
    halt_i <= 1'b1;
    wr(ICS_ADR_CTRL, 8'h00);
    halt_i <= 1'b0;
    rd(ICS_ADR_CTRL, 8'h35, "halt frozen");
    wr(ICS_ADR_CTRL, 8'h37);
    wr(ICS_ADR_CTRL, 8'h02);
    rd(ICS_ADR_CTRL, 8'h02, "disable keeps stop");
    chk1("off", 1'b0, periph_on_o);
    chk8("pin drive levels", 8'h00, {6'h00, scl_o, sda_o});
    chk8("ack slots driven", 8'h02, n_acks[7:0]);
    chk8("tx loads", 8'h03, n_loads[7:0]);
    $display("test halt and disable done");
    print_verdict();
  end
endmodule // test_ics_ctrl
